// >>> mafc_checker.sv
// What this block does
// - Sixteen 2-bit domain settings packed in one 32-bit register.
// - Domain setting 00 faults translated accesses as a domain fault unless an alignment, external or translation fault comes first.
// - Client setting 01 checks access against descriptor permission bits.
// - Setting 00 or reserved 10 raises section or page domain fault.
// - Manager setting 11 skips permission checks entirely.
// - Data fault raises data abort, records code, domain and address.
// - Fetch fault only flags instruction abort; records stay unchanged.
// - Translation off passes address through with no permission checks.
// - Access bits 00 graded by system and ROM bits; writes fault.
// - Access bits 01 allow supervisor only.
// - Access bits 10 allow user reads, fault user writes.
// - Access bits 11 allow everything unless system and ROM bits are both set.
// - Both system and ROM bits set is reserved and faults.
// - Alignment check on halfword and word data, even untranslated.
// - Alignment fault aborts before any domain or permission check.
// - Unchecked misaligned accesses go to the enclosing aligned address.
// - Descriptor type bits 00 give section or page translation fault.
// - Level-1 domain field selects domain; check at descriptor return.
// - Permission checked with domain; system bit sits in control bit 8.
// - Pages pick one of four subpage fields by address quarter.
// - An aborted swap read suppresses the following write.
// - Aborted line fill invalidates line; fetch aborts if abort at/before its word.
// - Data abort fault codes for domain and permission faults.
// - Alignment records code 0001 and has highest priority.
// Assumes the core presents one check request per cycle with descriptors already fetched.
//
// Implementation choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "mafc_consts.svh"
module mafc_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic acc_valid,
    input wire logic acc_is_fetch,
    input wire logic acc_is_write,
    input wire logic acc_is_user,
    input wire logic acc_is_swap,
    input wire logic [1:0] acc_size,
    input wire logic [31:0] acc_vaddr,
    input wire logic acc_is_page,
    input wire logic [31:0] l1_desc,
    input wire logic [31:0] l2_desc,
    input wire logic ext_l1_abort,
    input wire logic ext_l2_abort,
    input wire logic fill_start,
    input wire logic [2:0] fill_req_word,
    input wire logic [31:0] fill_line_vaddr,
    input wire logic fill_word_valid,
    input wire logic ext_abort,
    input wire logic swap_read_done,
    output logic [31:0] phys_addr,
    output logic data_abort,
    output logic instruction_abort,
    output logic swap_write_en,
    output logic line_invalidate
);
    import mafc_pkg::*;
    mafc_regs_s r;
    mafc_regs_s next_r;
    mafc_phase_e phase;
    mafc_phase_e next_phase;
    logic [2:0] fill_cnt;
    logic [2:0] next_fill_cnt;
    logic fill_aborted;
    logic next_fill_aborted;
    logic [31:0] out_pa;
    logic [31:0] next_out_pa;
    logic out_data_abort;
    logic next_out_data_abort;
    logic out_instruction_abort;
    logic next_out_instruction_abort;
    logic out_swap_we;
    logic next_out_swap_we;
    logic out_line_inv;
    logic next_out_line_inv;
    logic [3:0] swap_dom;
    logic [3:0] next_swap_dom;
    logic swap_page;
    logic next_swap_page;
    logic [31:0] swap_va;
    logic [31:0] next_swap_va;
    logic [3:0] dom_num;
    logic [1:0] dom_set;
    logic [1:0] sel_ap;
    logic mmu_on;
    logic misaligned;
    logic desc_bad;
    logic perm_fault;
    logic dom_fault;
    logic any_fault;
    logic [3:0] fcode;
    logic bus_req;
    logic [31:0] wmask;

    assign mmu_on = r.ctrl[`MAFC_CTRL_MMU_EN];
    assign dom_num = l1_desc[`MAFC_L1_DOM_LSB +: 4];
    assign dom_set = r.domain_permission_settings[{dom_num, 1'b0} +: 2];
    // Page quarters come from the two address bits above the 1K subpage span.
    assign sel_ap = acc_is_page ?
        l2_desc[`MAFC_SUBPAGE_LSB + {acc_vaddr[`MAFC_SUBPAGE_SEL_LSB +: 2], 1'b0} +: 2] :
        l1_desc[`MAFC_SECT_AP_LSB +: 2];
    assign misaligned = r.ctrl[`MAFC_CTRL_ALIGN_EN] && !acc_is_fetch &&
        (((acc_size == `MAFC_SIZE_HALF) && acc_vaddr[0]) ||
         ((acc_size == `MAFC_SIZE_WORD) && (acc_vaddr[1:0] != 2'h0)));
    assign desc_bad = (l1_desc[1:0] == `MAFC_DESC_INVALID) ||
        (acc_is_page && (l2_desc[1:0] == `MAFC_DESC_INVALID));
    assign dom_fault = (dom_set == `MAFC_DOM_NONE) || (dom_set == `MAFC_DOM_RSVD);

    mafc_perm_eval i_mafc_perm_eval (
        .access_perm_bits(sel_ap),
        .sys_prot(r.ctrl[`MAFC_CTRL_SYS_PROT]),
        .rom_prot(r.ctrl[`MAFC_CTRL_ROM_PROT]),
        .is_user(acc_is_user),
        .is_write(acc_is_write),
        .perm_fault(perm_fault)
    );

    // Priority chain: alignment first, then external descriptor aborts, translation, domain, permission.
    always_comb begin
        any_fault = 1'b1;
        fcode = `MAFC_FC_ALIGN;
        if (misaligned) begin
            fcode = `MAFC_FC_ALIGN;
        end else if (!mmu_on) begin
            any_fault = 1'b0;
        end else if (ext_l1_abort) begin
            fcode = `MAFC_FC_EXT_L1;
        end else if (acc_is_page && ext_l2_abort) begin
            fcode = `MAFC_FC_EXT_L2;
        end else if (desc_bad) begin
            fcode = (l1_desc[1:0] == `MAFC_DESC_INVALID) ? `MAFC_FC_TRANS_SEC : `MAFC_FC_TRANS_PAGE;
        end else if (dom_fault) begin
            fcode = acc_is_page ? `MAFC_FC_DOM_PAGE : `MAFC_FC_DOM_SEC;
        end else if ((dom_set == `MAFC_DOM_CLIENT) && perm_fault) begin
            fcode = acc_is_page ? `MAFC_FC_PERM_PAGE : `MAFC_FC_PERM_SEC;
        end else begin
            any_fault = 1'b0;
        end
    end

    assign bus_req = wb_cyc_i && wb_stb_i && !r.wb_ack;
    always_comb begin
        wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    end

    always_comb begin
        next_r = r;
        next_r.wb_ack = bus_req;
        next_phase = phase;
        next_fill_cnt = fill_cnt;
        next_fill_aborted = fill_aborted;
        next_out_data_abort = 1'b0;
        next_out_instruction_abort = 1'b0;
        next_out_swap_we = 1'b0;
        next_out_line_inv = 1'b0;
        next_out_pa = out_pa;
        next_swap_dom = swap_dom;
        next_swap_page = swap_page;
        next_swap_va = swap_va;
        if (bus_req) begin
            if (wb_adr_i == `MAFC_OFF_DOMAIN) begin
                next_r.wb_dat = r.domain_permission_settings;
                if (wb_we_i) begin
                    next_r.domain_permission_settings = (r.domain_permission_settings & ~wmask) | (wb_dat_i & wmask);
                end
            end else if (wb_adr_i == `MAFC_OFF_CTRL) begin
                next_r.wb_dat = r.ctrl;
                if (wb_we_i) begin
                    next_r.ctrl = ((r.ctrl & ~wmask) | (wb_dat_i & wmask)) & `MAFC_CTRL_MASK;
                end
            end else if (wb_adr_i == `MAFC_OFF_FSR) begin
                next_r.wb_dat = {24'h0, r.fault_status_reg};
            end else if (wb_adr_i == `MAFC_OFF_FAR) begin
                next_r.wb_dat = r.fault_address_reg;
            end else begin
                next_r.wb_dat = 32'h0;
            end
        end
        if (acc_valid && phase == MAFC_IDLE) begin
            // A misaligned read fetches the enclosing word; a write stays on its own boundary.
            if ((acc_size == `MAFC_SIZE_WORD) || ((acc_size == `MAFC_SIZE_HALF) && !acc_is_write && acc_vaddr[0])) begin
                next_out_pa = {acc_vaddr[31:2], 2'h0};
            end else if (acc_size == `MAFC_SIZE_HALF) begin
                next_out_pa = {acc_vaddr[31:1], 1'b0};
            end else begin
                next_out_pa = acc_vaddr;
            end
            if (any_fault && acc_is_fetch) begin
                next_out_instruction_abort = 1'b1;
            end else if (any_fault) begin
                next_out_data_abort = 1'b1;
                next_r.fault_status_reg = {dom_num, fcode};
                next_r.fault_address_reg = acc_vaddr;
            end else if (acc_is_swap) begin
                next_phase = MAFC_SWAP_WAIT;
                next_swap_dom = dom_num;
                next_swap_page = acc_is_page;
                next_swap_va = acc_vaddr;
            end
        end
        case (phase)
            MAFC_SWAP_WAIT: begin
                if (swap_read_done) begin
                    next_phase = MAFC_IDLE;
                    next_out_swap_we = !ext_abort;
                    if (ext_abort) begin
                        next_out_data_abort = 1'b1;
                        // The core may present other requests meanwhile, so the swap's own view is used.
                        next_r.fault_status_reg = {swap_dom, swap_page ? `MAFC_FC_EXT_NCNB_PAGE : `MAFC_FC_EXT_NCNB_SEC};
                        next_r.fault_address_reg = swap_va;
                    end
                end
            end
            MAFC_LINE_FILL: begin
                if (fill_word_valid) begin
                    next_fill_cnt = fill_cnt + 3'h1;
                    if (ext_abort) begin
                        next_fill_aborted = 1'b1;
                        next_out_instruction_abort = !fill_aborted && (fill_cnt <= fill_req_word);
                    end
                    if (fill_cnt == `MAFC_LINE_WORDS) begin
                        next_phase = MAFC_IDLE;
                        next_out_line_inv = fill_aborted || ext_abort;
                    end
                end
            end
            default: begin
                if (fill_start && !(acc_valid && acc_is_swap)) begin
                    next_phase = MAFC_LINE_FILL;
                    next_fill_cnt = 3'h0;
                    next_fill_aborted = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            r <= '0;
            phase <= MAFC_IDLE;
            fill_cnt <= 3'h0;
            fill_aborted <= 1'b0;
            out_pa <= 32'h0;
            out_data_abort <= 1'b0;
            out_instruction_abort <= 1'b0;
            out_swap_we <= 1'b0;
            out_line_inv <= 1'b0;
            swap_dom <= 4'h0;
            swap_page <= 1'b0;
            swap_va <= 32'h0;
        end else begin
            r <= next_r;
            phase <= next_phase;
            fill_cnt <= next_fill_cnt;
            fill_aborted <= next_fill_aborted;
            out_pa <= next_out_pa;
            out_data_abort <= next_out_data_abort;
            out_instruction_abort <= next_out_instruction_abort;
            out_swap_we <= next_out_swap_we;
            out_line_inv <= next_out_line_inv;
            swap_dom <= next_swap_dom;
            swap_page <= next_swap_page;
            swap_va <= next_swap_va;
        end
    end

    assign wb_dat_o = r.wb_dat;
    assign wb_ack_o = r.wb_ack;
    assign phys_addr = out_pa;
    assign data_abort = out_data_abort;
    assign instruction_abort = out_instruction_abort;
    assign swap_write_en = out_swap_we;
    assign line_invalidate = out_line_inv;

    // Helper view of a request that the checker takes in this cycle.
    logic chk_req;
    assign chk_req = acc_valid && phase == MAFC_IDLE;

    property p_dom_none;
        @(posedge clk) disable iff (!rst_n)
        chk_req && mmu_on && !misaligned && !ext_l1_abort && !ext_l2_abort && !desc_bad &&
        !acc_is_fetch && dom_set == `MAFC_DOM_NONE |=>
        data_abort && r.fault_status_reg[3:0] inside {`MAFC_FC_DOM_SEC, `MAFC_FC_DOM_PAGE};
    endproperty
    a_dom_none: assert property (p_dom_none) else $error("domain none did not fault");

    property p_dom_rsvd;
        @(posedge clk) disable iff (!rst_n)
        chk_req && mmu_on && !misaligned && !desc_bad && !ext_l1_abort && !ext_l2_abort &&
        dom_set == `MAFC_DOM_RSVD && acc_is_fetch |=> instruction_abort && !data_abort;
    endproperty
    a_dom_rsvd: assert property (p_dom_rsvd) else $error("reserved domain fetch not aborted");

    property p_manager;
        @(posedge clk) disable iff (!rst_n)
        chk_req && mmu_on && !misaligned && !desc_bad && !ext_l1_abort && !ext_l2_abort &&
        dom_set == `MAFC_DOM_MANAGER |=> !data_abort && !instruction_abort;
    endproperty
    a_manager: assert property (p_manager) else $error("manager access faulted");

    property p_fetch_keeps;
        @(posedge clk) disable iff (!rst_n)
        chk_req && acc_is_fetch && any_fault |=> instruction_abort && $stable(r.fault_address_reg);
    endproperty
    a_fetch_keeps: assert property (p_fetch_keeps) else $error("fetch fault touched records");

    property p_mmu_off;
        @(posedge clk) disable iff (!rst_n)
        chk_req && !mmu_on && !misaligned |=> !data_abort && !instruction_abort;
    endproperty
    a_mmu_off: assert property (p_mmu_off) else $error("fault with translation off");

    property p_align;
        @(posedge clk) disable iff (!rst_n)
        chk_req && misaligned |=> data_abort && r.fault_status_reg[3:0] == `MAFC_FC_ALIGN &&
        r.fault_address_reg == $past(acc_vaddr);
    endproperty
    a_align: assert property (p_align) else $error("alignment fault not recorded");

    property p_user_ap01;
        @(posedge clk) disable iff (!rst_n)
        chk_req && mmu_on && !misaligned && !desc_bad && !ext_l1_abort && !ext_l2_abort &&
        dom_set == `MAFC_DOM_CLIENT && sel_ap == 2'h1 && acc_is_user && !acc_is_fetch |=> data_abort;
    endproperty
    a_user_ap01: assert property (p_user_ap01) else $error("user access to supervisor page allowed");

    property p_swap_sup;
        @(posedge clk) disable iff (!rst_n)
        phase == MAFC_SWAP_WAIT && swap_read_done && ext_abort |=> !swap_write_en && data_abort;
    endproperty
    a_swap_sup: assert property (p_swap_sup) else $error("swap write after aborted read");

    property p_fill_inv;
        @(posedge clk) disable iff (!rst_n)
        phase == MAFC_LINE_FILL && fill_word_valid && ext_abort && fill_cnt == `MAFC_LINE_WORDS |=> line_invalidate;
    endproperty
    a_fill_inv: assert property (p_fill_inv) else $error("aborted line not invalidated");

    c_data_abort: cover property (@(posedge clk) disable iff (!rst_n) data_abort);
    c_inst_abort: cover property (@(posedge clk) disable iff (!rst_n) instruction_abort);
    c_swap_ok: cover property (@(posedge clk) disable iff (!rst_n) swap_write_en);
    c_line_inv: cover property (@(posedge clk) disable iff (!rst_n) line_invalidate);
endmodule // mafc_checker

// >>> mafc_consts.svh
// Constants for the access fault checker: register offsets, field positions, fault codes.
// Assumes inclusion by the checker and the bench files by bare name.
`ifndef MAFC_CONSTS_SVH
`define MAFC_CONSTS_SVH
`define MAFC_OFF_DOMAIN 4'h0
`define MAFC_OFF_CTRL 4'h4
`define MAFC_OFF_FSR 4'h8
`define MAFC_OFF_FAR 4'hc
`define MAFC_CTRL_MMU_EN 0
`define MAFC_CTRL_ALIGN_EN 1
`define MAFC_CTRL_SYS_PROT 8
`define MAFC_CTRL_ROM_PROT 9
`define MAFC_CTRL_MASK 32'h0000_0303
`define MAFC_DOM_NONE 2'h0
`define MAFC_DOM_CLIENT 2'h1
`define MAFC_DOM_RSVD 2'h2
`define MAFC_DOM_MANAGER 2'h3
`define MAFC_FC_ALIGN 4'h1
`define MAFC_FC_EXT_L1 4'hc
`define MAFC_FC_EXT_L2 4'he
`define MAFC_FC_TRANS_SEC 4'h5
`define MAFC_FC_TRANS_PAGE 4'h7
`define MAFC_FC_DOM_SEC 4'h9
`define MAFC_FC_DOM_PAGE 4'hb
`define MAFC_FC_PERM_SEC 4'hd
`define MAFC_FC_PERM_PAGE 4'hf
`define MAFC_FC_EXT_LINE_SEC 4'h4
`define MAFC_FC_EXT_LINE_PAGE 4'h6
`define MAFC_FC_EXT_NCNB_SEC 4'h8
`define MAFC_FC_EXT_NCNB_PAGE 4'ha
`define MAFC_DESC_INVALID 2'h0
`define MAFC_SIZE_HALF 2'h1
`define MAFC_SIZE_WORD 2'h2
`define MAFC_L1_DOM_LSB 5
`define MAFC_SUBPAGE_LSB 4
`define MAFC_SUBPAGE_SEL_LSB 10
`define MAFC_SECT_AP_LSB 10
`define MAFC_LINE_WORDS 3'h7
`endif

// >>> mafc_mem_model.sv
// Behavioural model of the external memory side: line-fill beats and swap reads, with optional aborts.
// Assumes the bench commands it by one-cycle pulses and watches busy for completion.
`timescale 1ns/1ps
module mafc_mem_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cmd_fill,
    input wire logic cmd_swap,
    input wire logic [3:0] abort_at,
    input wire logic swap_abort,
    input wire logic slow,
    output logic fill_word_valid,
    output logic ext_abort,
    output logic swap_read_done,
    output logic busy
);
    logic fill_on;
    logic sw_on;
    logic gap;
    logic [3:0] beat;
    logic [1:0] swdly;
    assign busy = fill_on | sw_on;
    // A slow memory inserts an idle cycle between beats, so the checker must not assume back-to-back data.
    always_ff @(posedge clk) begin
        fill_word_valid <= 1'b0;
        ext_abort <= 1'b0;
        swap_read_done <= 1'b0;
        if (!rst_n) begin
            fill_on <= 1'b0;
            sw_on <= 1'b0;
            gap <= 1'b0;
            beat <= 4'h0;
            swdly <= 2'h0;
        end else begin
            if (cmd_fill) begin
                fill_on <= 1'b1;
                beat <= 4'h0;
                gap <= 1'b0;
            end else if (fill_on) begin
                gap <= ~gap;
                if (!slow || gap) begin
                    fill_word_valid <= 1'b1;
                    ext_abort <= (beat == abort_at);
                    beat <= beat + 4'h1;
                    fill_on <= (beat != 4'h7);
                end
            end
            if (cmd_swap) begin
                sw_on <= 1'b1;
                swdly <= slow ? 2'h3 : 2'h0;
            end else if (sw_on) begin
                if (swdly == 2'h0) begin
                    swap_read_done <= 1'b1;
                    ext_abort <= swap_abort;
                    sw_on <= 1'b0;
                end else begin
                    swdly <= swdly - 2'h1;
                end
            end
        end
    end
endmodule // mafc_mem_model

// >>> mafc_perm_eval.sv
// Pure permission evaluator for one client-domain access.
// Assumes its inputs are stable within the cycle; it holds no state.
`timescale 1ns/1ps
module mafc_perm_eval (
    input wire logic [1:0] access_perm_bits,
    input wire logic sys_prot,
    input wire logic rom_prot,
    input wire logic is_user,
    input wire logic is_write,
    output logic perm_fault
);
    always_comb begin
        if (sys_prot && rom_prot) begin
            perm_fault = 1'b1;
        end else begin
            case (access_perm_bits)
                2'h0: begin
                    perm_fault = is_write || (!sys_prot && !rom_prot) || (sys_prot && is_user);
                end
                2'h1: perm_fault = is_user;
                2'h2: perm_fault = is_user && is_write;
                default: perm_fault = 1'b0;
            endcase
        end
    end
endmodule // mafc_perm_eval

// >>> mafc_pkg.sv
// Types shared by the access fault checker files.
// Assumes mafc_consts.svh is reachable by bare name.
package mafc_pkg;
    typedef enum logic [1:0] {
        MAFC_IDLE,
        MAFC_SWAP_WAIT,
        MAFC_LINE_FILL
    } mafc_phase_e;
    typedef struct packed {
        logic [31:0] domain_permission_settings;
        logic [31:0] ctrl;
        logic [7:0] fault_status_reg;
        logic [31:0] fault_address_reg;
        logic wb_ack;
        logic [31:0] wb_dat;
    } mafc_regs_s;
endpackage

// >>> tb_mafc_checker.sv
// Self-checking bench for the access fault checker: table of permission cases, then hand tests.
// Assumes the memory model file is compiled first; registers are reached over classic Wishbone.
`timescale 1ns/1ps
`include "mafc_consts.svh"
module tb_mafc_checker;
    typedef struct packed {
        logic [1:0] dom;
        logic [1:0] ap;
        logic sys;
        logic rom;
        logic usr;
        logic wr;
        logic pg;
        logic [3:0] fc;
    } mafc_row_s;
    localparam logic [31:0] VA = 32'h1234_5800;
    logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [3:0] adr = 4'h0, sel = 4'h0, abort_at = 4'h8;
    logic [31:0] wdat = 32'h0, rdat, q, l1 = 32'h0, l2 = 32'h0, va = 32'h0, phys_addr, exp_fsr, exp_far;
    logic ack, valid = 1'b0, fetch = 1'b0, awr = 1'b0, usr = 1'b0, swap = 1'b0, pg = 1'b0;
    logic [1:0] sz = 2'h0;
    logic fill_start = 1'b0, cmd_fill = 1'b0, cmd_swap = 1'b0, swap_abort = 1'b0, slow = 1'b0;
    logic [2:0] req_word = 3'h0;
    logic fwv, xab, srd, busy, data_abort, instruction_abort, swap_write_en, line_invalidate;
    logic [7:0] n_ev [4] = '{default: 8'h0};
    logic [7:0] base [4] = '{default: 8'h0};
    int n_mismatch = 0;
    int compares = 0;
    mafc_row_s rows [16] = '{
        '{2'h0, 2'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 4'h9}, '{2'h2, 2'h3, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 4'hb},
        '{2'h3, 2'h0, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0, 4'h0}, '{2'h1, 2'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 4'hd},
        '{2'h1, 2'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 4'h0}, '{2'h1, 2'h0, 1'h1, 1'h0, 1'h1, 1'h0, 1'h0, 4'hd},
        '{2'h1, 2'h0, 1'h1, 1'h0, 1'h0, 1'h1, 1'h1, 4'hf}, '{2'h1, 2'h0, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0, 4'h0},
        '{2'h1, 2'h0, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 4'hd}, '{2'h1, 2'h1, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 4'h0},
        '{2'h1, 2'h1, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 4'hd}, '{2'h1, 2'h2, 1'h0, 1'h0, 1'h1, 1'h0, 1'h1, 4'h0},
        '{2'h1, 2'h2, 1'h0, 1'h0, 1'h1, 1'h1, 1'h1, 4'hf}, '{2'h1, 2'h3, 1'h0, 1'h1, 1'h1, 1'h1, 1'h0, 4'h0},
        '{2'h1, 2'h3, 1'h1, 1'h1, 1'h0, 1'h0, 1'h1, 4'hf}, '{2'h1, 2'h1, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0, 4'h0}};
    mafc_checker i_mafc_checker (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .acc_valid(valid),
        .acc_is_fetch(fetch), .acc_is_write(awr), .acc_is_user(usr), .acc_is_swap(swap), .acc_size(sz),
        .acc_vaddr(va), .acc_is_page(pg), .l1_desc(l1), .l2_desc(l2), .ext_l1_abort(1'b0), .ext_l2_abort(1'b0),
        .fill_start(fill_start), .fill_req_word(req_word), .fill_line_vaddr(32'h0), .fill_word_valid(fwv),
        .ext_abort(xab), .swap_read_done(srd), .phys_addr(phys_addr), .data_abort(data_abort),
        .instruction_abort(instruction_abort), .swap_write_en(swap_write_en), .line_invalidate(line_invalidate));
    mafc_mem_model i_mafc_mem_model (.clk(clk), .rst_n(rst_n), .cmd_fill(cmd_fill), .cmd_swap(cmd_swap),
        .abort_at(abort_at), .swap_abort(swap_abort), .slow(slow), .fill_word_valid(fwv), .ext_abort(xab),
        .swap_read_done(srd), .busy(busy));
    initial begin
        forever #4 clk = ~clk;
    end
    // Pulses last one cycle, so they are counted at every edge rather than sampled at a guessed time.
    always @(posedge clk) begin
        n_ev[0] <= n_ev[0] + 8'(data_abort === 1'b1);
        n_ev[1] <= n_ev[1] + 8'(instruction_abort === 1'b1);
        n_ev[2] <= n_ev[2] + 8'(swap_write_en === 1'b1);
        n_ev[3] <= n_ev[3] + 8'(line_invalidate === 1'b1);
    end
    task automatic conclude();
        if (n_mismatch == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_cnt(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t count got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic ev(input logic [7:0] da, input logic [7:0] ia, input logic [7:0] sw, input logic [7:0] li);
        chk_cnt(n_ev[0] - base[0], da);
        chk_cnt(n_ev[1] - base[1], ia);
        chk_cnt(n_ev[2] - base[2], sw);
        chk_cnt(n_ev[3] - base[3], li);
        base = n_ev;
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, 4'hf, d};
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (ack === 1'b1) break;
        end
        q = rdat;
        if (i == 50) begin
            n_mismatch++;
            conclude();
        end
        {cyc, stb} <= 2'b00;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk32(q, exp);
    endtask
    task automatic acc(input logic [4:0] f, input logic [1:0] s, input logic [31:0] a, input logic [31:0] d1,
                       input logic [31:0] d2);
        @(posedge clk);
        {valid, fetch, awr, usr, swap, pg, sz, va, l1, l2} <= {1'b1, f, s, a, d1, d2};
        @(posedge clk);
        valid <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    task automatic mem_wait();
        int i;
        @(posedge clk);
        {cmd_fill, cmd_swap, fill_start} <= 3'b000;
        // The model raises busy on the command edge, so busy is first read one edge later.
        @(posedge clk);
        for (i = 0; i < 60 && busy !== 1'b0; i++) @(posedge clk);
        if (i == 60) begin
            n_mismatch++;
            conclude();
        end
        repeat (3) @(posedge clk);
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        for (int a = 0; a < 16; a += 2) rd(4'(a), 32'h0);
        wb(1'b1, `MAFC_OFF_CTRL, 32'hffff_ffff);
        wb(1'b1, `MAFC_OFF_FSR, 32'hffff_ffff);
        rd(`MAFC_OFF_CTRL, `MAFC_CTRL_MASK);
        rd(`MAFC_OFF_FSR, 32'h0);
        exp_fsr = 32'h0;
        exp_far = 32'h0;
        for (int r = 0; r < 16; r++) begin
            wb(1'b1, `MAFC_OFF_DOMAIN, 32'(rows[r].dom) << 6);
            wb(1'b1, `MAFC_OFF_CTRL, {22'h0, rows[r].rom, rows[r].sys, 8'h3});
            acc({1'b0, rows[r].wr, rows[r].usr, 1'b0, rows[r].pg}, `MAFC_SIZE_WORD, VA,
                32'h60 | 32'(rows[r].ap) << 10 | (rows[r].pg ? 32'h1 : 32'h2),
                {20'h0, ~rows[r].ap, rows[r].ap, ~rows[r].ap, ~rows[r].ap, 4'h2});
            if (rows[r].fc != 4'h0) begin
                exp_fsr = {24'h0, 4'h3, rows[r].fc};
                exp_far = VA;
            end
            ev({7'h0, rows[r].fc != 4'h0}, 8'h0, 8'h0, 8'h0);
            rd(`MAFC_OFF_FSR, exp_fsr);
            rd(`MAFC_OFF_FAR, exp_far);
        end
        wb(1'b1, `MAFC_OFF_DOMAIN, 32'h0000_0080);
        wb(1'b1, `MAFC_OFF_CTRL, 32'h3);
        acc(5'h0, `MAFC_SIZE_HALF, 32'h1001, 32'h0, 32'h0);
        ev(8'h1, 8'h0, 8'h0, 8'h0);
        rd(`MAFC_OFF_FSR, 32'h01);
        acc(5'h10, `MAFC_SIZE_WORD, 32'h2002, 32'h62, 32'h0);
        ev(8'h0, 8'h1, 8'h0, 8'h0);
        rd(`MAFC_OFF_FSR, 32'h01);
        rd(`MAFC_OFF_FAR, 32'h1001);
        acc(5'h0, `MAFC_SIZE_WORD, 32'h2000, 32'h0, 32'h0);
        rd(`MAFC_OFF_FSR, 32'h05);
        wb(1'b1, `MAFC_OFF_DOMAIN, 32'hffff_ffff);
        acc(5'h1, `MAFC_SIZE_WORD, 32'h2000, 32'h61, 32'h0);
        rd(`MAFC_OFF_FSR, 32'h37);
        ev(8'h2, 8'h0, 8'h0, 8'h0);
        wb(1'b1, `MAFC_OFF_CTRL, 32'h2);
        acc(5'h0, `MAFC_SIZE_HALF, 32'h2003, 32'h0, 32'h0);
        ev(8'h1, 8'h0, 8'h0, 8'h0);
        wb(1'b1, `MAFC_OFF_CTRL, 32'h0);
        acc(5'h8, `MAFC_SIZE_WORD, 32'h2003, 32'h0, 32'h0);
        ev(8'h0, 8'h0, 8'h0, 8'h0);
        chk32(phys_addr, 32'h2000);
        acc(5'h0, `MAFC_SIZE_HALF, 32'h2003, 32'h0, 32'h0);
        chk32(phys_addr, 32'h2000);
        wb(1'b1, `MAFC_OFF_CTRL, 32'h1);
        // The second request arrives mid-swap and must be ignored even though it would fault.
        for (int k = 0; k < 2; k++) begin
            acc(5'h2, `MAFC_SIZE_WORD, 32'h3000, 32'h62, 32'h0);
            acc(5'h0, `MAFC_SIZE_WORD, 32'h3000, 32'h0, 32'h0);
            {swap_abort, slow, cmd_swap} <= {k == 0, k == 1, 1'b1};
            mem_wait();
            ev({7'h0, k == 0}, 8'h0, {7'h0, k == 1}, 8'h0);
        end
        rd(`MAFC_OFF_FSR, 32'h38);
        for (int k = 0; k < 3; k++) begin
            abort_at <= (k == 0) ? 4'h3 : (k == 1) ? 4'h7 : 4'h8;
            {fill_start, cmd_fill, req_word, slow} <= {2'b11, 3'h3, k == 1};
            mem_wait();
            ev(8'h0, {7'h0, k == 0}, 8'h0, {7'h0, k != 2});
        end
        conclude();
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        conclude();
    end
endmodule // tb_mafc_checker
